// *** core/sfcs_pkg.sv ***
/*
 * Shared constants and carrier types of the SPI FIFO control and status block.
 * Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
 */
package sfcs_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_RX_DATA = 8'h10;
   localparam logic [7:0] ADDR_TX_DATA = 8'h20;
   localparam logic [7:0] ADDR_FIFO_CTL = 8'h40;
   localparam logic [7:0] ADDR_FIFO_STS = 8'h44;
   localparam logic [7:0] ADDR_EVT_STS = 8'h48;
   localparam logic [7:0] ADDR_EVT_CLR = 8'h4c;
   localparam logic [7:0] ADDR_EVT_EN = 8'h50;

   localparam logic [31:0] FIFO_CTL_RESET = 32'h2200_0000;
   localparam logic [31:0] FIFO_STS_RESET = 32'h0500_0000;

   // ------------------------------------------------------------------
   // Field positions of the control word
   // ------------------------------------------------------------------
   localparam int CTL_TX_MARK_LSB = 28;
   localparam int CTL_RX_MARK_LSB = 24;
   localparam int CTL_IDLE_EN = 21;
   localparam int CTL_OV_EN = 6;
   localparam int CTL_TX_EN = 3;
   localparam int CTL_RX_EN = 2;
   localparam int CTL_TX_FLUSH = 1;
   localparam int CTL_RX_FLUSH = 0;

   // ------------------------------------------------------------------
   // Field positions of the status word, shared by the event registers
   // ------------------------------------------------------------------
   localparam int STS_TX_CNT_LSB = 28;
   localparam int STS_TX_FULL = 27;
   localparam int STS_TX_EMPTY = 26;
   localparam int STS_RX_FULL = 25;
   localparam int STS_RX_EMPTY = 24;
   localparam int STS_IDLE = 20;
   localparam int STS_UNIT_DONE = 16;
   localparam int STS_RX_CNT_LSB = 12;
   localparam int STS_TARGET_START = 11;
   localparam int STS_TX_MARK = 4;
   localparam int STS_OVERFLOW = 2;
   localparam int STS_RX_MARK = 0;
   localparam logic [31:0] EVT_MASK = 32'h0011_0804;

   // ------------------------------------------------------------------
   // Receive idle limits
   // ------------------------------------------------------------------
   localparam int IDLE_CNT_W = 10;
   localparam logic [IDLE_CNT_W-1:0] IDLE_MASTER_SCLK = 10'd64;
   localparam logic [IDLE_CNT_W-1:0] IDLE_SLAVE_PCLK = 10'd576;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] tx_mark;
      logic [1:0] rx_mark;
      logic recv_idle_irq_enable;
      logic recv_overflow_irq_enable;
      logic xmit_mark_irq_enable;
      logic recv_mark_irq_enable;
   } sfcs_ctl_t;

   typedef struct packed {
      logic tx_full;
      logic tx_empty;
      logic rx_full;
      logic rx_empty;
      logic unit_done;
      logic target_start_flag;
   } sfcs_mirror_t;

endpackage

// *** core/sfcs_fifo.sv ***
/*
 * Flip-flop queue with fill count and one-cycle flush.
 * Assumes DEPTH is a power of two; pushes when full and pops when empty are ignored.
 */
`timescale 1ns/100ps
`default_nettype none
module sfcs_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic [$clog2(DEPTH+1)-1:0] count,
   output logic full,
   output logic empty
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic do_push;
   logic do_pop;

   assign full = (count_reg == CW'(DEPTH));
   assign empty = (count_reg == '0);
   assign do_push = push & ~full & ~flush;
   assign do_pop = pop & ~empty & ~flush;
   assign head = mem[rd_ptr_reg];
   assign count = count_reg;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem[i] <= '0;
         end else if (do_push && wr_ptr_reg == PW'(i)) begin
            mem[i] <= push_data;
         end
      end
   end

   // ------------------------------------------------------------------
   // Pointers and count
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= do_push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
         rd_ptr_reg <= do_pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
         count_reg <= CW'(count_reg + CW'(do_push) - CW'(do_pop));
      end
   end

endmodule
`default_nettype wire

// *** core/sfcs_top.sv ***
/*
 * FIFO control and status of an SPI controller: queues, marks, flush, idle time-out,
 * overflow, unit-done and target-start flags, APB registers and interrupt output.
 * Assumes the shift engine runs on pclk and strobes its events for one cycle, and that
 * the serial clock pin arrives asynchronously and is far slower than pclk.
 */
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sfcs_top #(
   parameter int DATA_W = 32,
   parameter int DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [sfcs_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic master_mode,
   input wire logic sclk_pin,
   output logic [DATA_W-1:0] eng_tx_data,
   output logic eng_tx_valid,
   input wire logic eng_tx_pop,
   input wire logic [DATA_W-1:0] eng_rx_data,
   input wire logic eng_rx_push,
   input wire logic eng_unit_done,
   input wire logic eng_three_wire_start,
   input wire logic eng_xfer_done,
   input wire logic mirror_unit_done_clr,
   input wire logic mirror_target_start_clr,
   output sfcs_pkg::sfcs_mirror_t mirror_out
);
   localparam int CW = $clog2(DEPTH+1);

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   logic ack_reg;
   logic err_reg;
   logic [31:0] prdata_reg;
   logic access;
   logic fire;
   logic wr_fire;
   logic rd_fire;
   logic sel_rx;
   logic sel_tx;
   logic sel_ctl;
   logic sel_sts;
   logic sel_evt;
   logic sel_clr;
   logic sel_en;
   logic mapped;
   logic [31:0] rd_word;

   assign access = psel & penable;
   assign fire = access & ack_reg;
   assign wr_fire = fire & pwrite & ~err_reg;
   assign rd_fire = fire & ~pwrite & ~err_reg;
   assign sel_rx = (paddr == sfcs_pkg::ADDR_RX_DATA);
   assign sel_tx = (paddr == sfcs_pkg::ADDR_TX_DATA);
   assign sel_ctl = (paddr == sfcs_pkg::ADDR_FIFO_CTL);
   assign sel_sts = (paddr == sfcs_pkg::ADDR_FIFO_STS);
   assign sel_evt = (paddr == sfcs_pkg::ADDR_EVT_STS);
   assign sel_clr = (paddr == sfcs_pkg::ADDR_EVT_CLR);
   assign sel_en = (paddr == sfcs_pkg::ADDR_EVT_EN);
   // Data registers are one-way: reading transmit data or writing receive data is refused.
   assign mapped = (sel_rx & ~pwrite) | (sel_tx & pwrite) | sel_ctl | sel_sts | sel_evt
                   | (sel_clr & pwrite) | sel_en;
   assign pready = ack_reg;
   assign pslverr = ack_reg & err_reg;
   assign prdata = prdata_reg;

   // One wait state lets read data be taken from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         ack_reg <= access & ~ack_reg;
         err_reg <= access & ~ack_reg & ~mapped;
         if (access && !ack_reg) begin
            prdata_reg <= (mapped && !pwrite) ? rd_word : '0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------------
   sfcs_pkg::sfcs_ctl_t ctl_reg;
   sfcs_pkg::sfcs_ctl_t ctl_next;
   logic xmit_flush_reg;
   logic recv_flush_reg;
   logic ctl_wr;

   assign ctl_wr = wr_fire & sel_ctl;

   always_comb begin
      ctl_next = ctl_reg;
      if (ctl_wr) begin
         ctl_next.tx_mark = pwdata[sfcs_pkg::CTL_TX_MARK_LSB +: 2];
         ctl_next.rx_mark = pwdata[sfcs_pkg::CTL_RX_MARK_LSB +: 2];
         ctl_next.recv_idle_irq_enable = pwdata[sfcs_pkg::CTL_IDLE_EN];
         ctl_next.recv_overflow_irq_enable = pwdata[sfcs_pkg::CTL_OV_EN];
         ctl_next.xmit_mark_irq_enable = pwdata[sfcs_pkg::CTL_TX_EN];
         ctl_next.recv_mark_irq_enable = pwdata[sfcs_pkg::CTL_RX_EN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= '{tx_mark: sfcs_pkg::FIFO_CTL_RESET[sfcs_pkg::CTL_TX_MARK_LSB +: 2],
                      rx_mark: sfcs_pkg::FIFO_CTL_RESET[sfcs_pkg::CTL_RX_MARK_LSB +: 2],
                      default: 1'b0};
         xmit_flush_reg <= 1'b0;
         recv_flush_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         // Flush bits live one cycle: set by a written one, dropped on the next cycle.
         xmit_flush_reg <= ctl_wr & pwdata[sfcs_pkg::CTL_TX_FLUSH];
         recv_flush_reg <= ctl_wr & pwdata[sfcs_pkg::CTL_RX_FLUSH];
      end
   end

   // ------------------------------------------------------------------
   // Queues
   // ------------------------------------------------------------------
   logic [CW-1:0] tx_cnt;
   logic [CW-1:0] rx_cnt;
   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic [DATA_W-1:0] rx_head;
   logic rx_pop;

   assign rx_pop = rd_fire & sel_rx & ~rx_empty;
   assign eng_tx_valid = ~tx_empty;

   sfcs_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(xmit_flush_reg),
      .push(wr_fire & sel_tx),
      .push_data(pwdata[DATA_W-1:0]),
      .pop(eng_tx_pop),
      .head(eng_tx_data),
      .count(tx_cnt),
      .full(tx_full),
      .empty(tx_empty)
   );

   // A push into a full queue is refused inside the queue, so the word is lost.
   sfcs_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(recv_flush_reg),
      .push(eng_rx_push),
      .push_data(eng_rx_data),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_cnt),
      .full(rx_full),
      .empty(rx_empty)
   );

   // ------------------------------------------------------------------
   // Fill marks
   // ------------------------------------------------------------------
   logic xmit_below_mark_flag;
   logic recv_above_mark_flag;

   assign xmit_below_mark_flag = (4'(tx_cnt) <= 4'(ctl_reg.tx_mark));
   assign recv_above_mark_flag = (4'(rx_cnt) > 4'(ctl_reg.rx_mark));

   // ------------------------------------------------------------------
   // Serial clock sampling
   // ------------------------------------------------------------------
   logic sclk_s1_reg;
   logic sclk_s2_reg;
   logic sclk_s3_reg;
   logic sclk_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_s3_reg <= 1'b0;
      end else begin
         sclk_s1_reg <= sclk_pin;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
      end
   end

   assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;

   // ------------------------------------------------------------------
   // Receive idle time-out
   // ------------------------------------------------------------------
   logic [sfcs_pkg::IDLE_CNT_W-1:0] idle_cnt_reg;
   logic [sfcs_pkg::IDLE_CNT_W-1:0] idle_cnt_next;
   logic [sfcs_pkg::IDLE_CNT_W-1:0] idle_limit;
   logic idle_tick;
   logic idle_restart;
   logic idle_set;

   // In master mode the count runs on serial clock periods, which stop between frames.
   assign idle_limit = master_mode ? sfcs_pkg::IDLE_MASTER_SCLK : sfcs_pkg::IDLE_SLAVE_PCLK;
   assign idle_tick = master_mode ? sclk_rise : 1'b1;
   assign idle_restart = rx_empty | rx_pop | recv_flush_reg;
   assign idle_set = idle_tick & ~idle_restart & (idle_cnt_reg == idle_limit);
   assign idle_cnt_next = idle_restart ? '0
                        : (idle_tick && idle_cnt_reg <= idle_limit)
                          ? sfcs_pkg::IDLE_CNT_W'(idle_cnt_reg + 1'b1) : idle_cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_reg <= '0;
      end else begin
         idle_cnt_reg <= idle_cnt_next;
      end
   end

   // ------------------------------------------------------------------
   // Sticky flags
   // ------------------------------------------------------------------
   logic idle_flag_reg;
   logic overflow_flag_reg;
   logic unit_done_reg;
   logic target_start_flag_reg;
   logic sts_wr;
   logic overflow_set;

   assign sts_wr = wr_fire & sel_sts;
   assign overflow_set = eng_rx_push & rx_full;

   // Every set below wins over a clear arriving in the same cycle, except that a receive pop blocks the idle set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_flag_reg <= 1'b0;
         overflow_flag_reg <= 1'b0;
         unit_done_reg <= 1'b0;
         target_start_flag_reg <= 1'b0;
      end else begin
         idle_flag_reg <= idle_set
            | (idle_flag_reg & ~rx_pop & ~(sts_wr & pwdata[sfcs_pkg::STS_IDLE]));
         overflow_flag_reg <= overflow_set
            | (overflow_flag_reg & ~(sts_wr & pwdata[sfcs_pkg::STS_OVERFLOW]));
         unit_done_reg <= eng_unit_done
            | (unit_done_reg & ~mirror_unit_done_clr
               & ~(sts_wr & pwdata[sfcs_pkg::STS_UNIT_DONE]));
         target_start_flag_reg <= eng_three_wire_start
            | (target_start_flag_reg & ~eng_xfer_done & ~mirror_target_start_clr
               & ~(sts_wr & pwdata[sfcs_pkg::STS_TARGET_START]));
      end
   end

   assign mirror_out = '{tx_full: tx_full, tx_empty: tx_empty,
                         rx_full: rx_full, rx_empty: rx_empty,
                         unit_done: unit_done_reg,
                         target_start_flag: target_start_flag_reg};

   // ------------------------------------------------------------------
   // Event capture for the interrupt registers
   // ------------------------------------------------------------------
   logic [31:0] evt_sts_reg;
   logic [31:0] evt_en_reg;
   logic [31:0] evt_set;
   logic [31:0] evt_clr;

   always_comb begin
      evt_set = '0;
      evt_set[sfcs_pkg::STS_IDLE] = idle_set;
      evt_set[sfcs_pkg::STS_UNIT_DONE] = eng_unit_done;
      evt_set[sfcs_pkg::STS_TARGET_START] = eng_three_wire_start;
      evt_set[sfcs_pkg::STS_OVERFLOW] = overflow_set;
   end

   assign evt_clr = (wr_fire & sel_clr) ? pwdata : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_sts_reg <= '0;
         evt_en_reg <= '0;
      end else begin
         evt_sts_reg <= (evt_set | (evt_sts_reg & ~evt_clr)) & sfcs_pkg::EVT_MASK;
         if (wr_fire && sel_en) begin
            evt_en_reg <= pwdata & sfcs_pkg::EVT_MASK;
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt request
   // ------------------------------------------------------------------
   logic irq_mark;
   logic irq_err;
   logic irq_evt;

   assign irq_mark = (ctl_reg.xmit_mark_irq_enable & xmit_below_mark_flag)
                   | (ctl_reg.recv_mark_irq_enable & recv_above_mark_flag);
   assign irq_err = (ctl_reg.recv_idle_irq_enable & idle_flag_reg)
                  | (ctl_reg.recv_overflow_irq_enable & overflow_flag_reg);
   assign irq_evt = |(evt_sts_reg & evt_en_reg);
   assign irq = irq_mark | irq_err | irq_evt;

   // ------------------------------------------------------------------
   // Read words
   // ------------------------------------------------------------------
   logic [31:0] ctl_word;
   logic [31:0] sts_word;

   always_comb begin
      ctl_word = '0;
      ctl_word[sfcs_pkg::CTL_TX_MARK_LSB +: 2] = ctl_reg.tx_mark;
      ctl_word[sfcs_pkg::CTL_RX_MARK_LSB +: 2] = ctl_reg.rx_mark;
      ctl_word[sfcs_pkg::CTL_IDLE_EN] = ctl_reg.recv_idle_irq_enable;
      ctl_word[sfcs_pkg::CTL_OV_EN] = ctl_reg.recv_overflow_irq_enable;
      ctl_word[sfcs_pkg::CTL_TX_EN] = ctl_reg.xmit_mark_irq_enable;
      ctl_word[sfcs_pkg::CTL_RX_EN] = ctl_reg.recv_mark_irq_enable;
      ctl_word[sfcs_pkg::CTL_TX_FLUSH] = xmit_flush_reg;
      ctl_word[sfcs_pkg::CTL_RX_FLUSH] = recv_flush_reg;
   end

   always_comb begin
      sts_word = '0;
      sts_word[sfcs_pkg::STS_TX_CNT_LSB +: 4] = 4'(tx_cnt);
      sts_word[sfcs_pkg::STS_TX_FULL] = tx_full;
      sts_word[sfcs_pkg::STS_TX_EMPTY] = tx_empty;
      sts_word[sfcs_pkg::STS_RX_FULL] = rx_full;
      sts_word[sfcs_pkg::STS_RX_EMPTY] = rx_empty;
      sts_word[sfcs_pkg::STS_IDLE] = idle_flag_reg;
      sts_word[sfcs_pkg::STS_UNIT_DONE] = unit_done_reg;
      sts_word[sfcs_pkg::STS_RX_CNT_LSB +: 4] = 4'(rx_cnt);
      sts_word[sfcs_pkg::STS_TARGET_START] = target_start_flag_reg;
      sts_word[sfcs_pkg::STS_TX_MARK] = xmit_below_mark_flag;
      sts_word[sfcs_pkg::STS_OVERFLOW] = overflow_flag_reg;
      sts_word[sfcs_pkg::STS_RX_MARK] = recv_above_mark_flag;
   end

   assign rd_word = sel_rx ? 32'(rx_head)
                  : sel_ctl ? ctl_word
                  : sel_sts ? sts_word
                  : sel_evt ? evt_sts_reg
                  : sel_en ? evt_en_reg
                  : '0;

endmodule
`default_nettype wire

// *** tb/sfcs_assertions.sv ***
/* Port checker of the SPI FIFO control block, bound into sfcs_top.
   Assumes the top module's port names, pclk and an active-low presetn. */
`timescale 1ns/100ps
`default_nettype none
module sfcs_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [sfcs_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic eng_tx_valid,
   input wire logic eng_unit_done,
   input wire logic eng_three_wire_start,
   input wire logic eng_xfer_done,
   input wire sfcs_pkg::sfcs_mirror_t mirror_out
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire ctl_wr;
   assign ctl_wr = psel && penable && pready && pwrite && paddr == sfcs_pkg::ADDR_FIFO_CTL;
   one_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("ready missing after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
      else $error("ready without access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   tx_flush_a:
      assert property (ctl_wr && pwdata[1] |=> ##1 mirror_out.tx_empty && !eng_tx_valid)
      else $error("transmit queue not empty after flush");
   rx_flush_a:
      assert property (ctl_wr && pwdata[0] |=> ##1 mirror_out.rx_empty && !mirror_out.rx_full)
      else $error("receive queue not empty after flush");
   tx_mirror_a:
      assert property (pready && !pwrite && !pslverr && paddr == sfcs_pkg::ADDR_FIFO_STS
         |-> prdata[27:24] == $past(mirror_out[5:2]))
      else $error("status full and empty bits differ from mirror");
   unit_set_a:
      assert property (eng_unit_done |=> mirror_out.unit_done)
      else $error("unit done not set");
   start_clr_a:
      assert property (eng_xfer_done && !eng_three_wire_start |=> !mirror_out.target_start_flag)
      else $error("start flag not cleared at done");
endmodule
bind sfcs_top sfcs_assertions u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .prdata(prdata), .eng_tx_valid(eng_tx_valid), .eng_unit_done(eng_unit_done),
   .eng_three_wire_start(eng_three_wire_start), .eng_xfer_done(eng_xfer_done),
   .mirror_out(mirror_out));
`default_nettype wire

// *** tb/sfcs_engine_model.sv ***
/* Model of the shift engine and remote serial clock beside the block.
   Assumes its tasks are called by the bench from a pclk-timed process. */
`timescale 1ns/100ps
`default_nettype none
module sfcs_engine_model (
   input wire logic pclk,
   output logic sclk_pin,
   output logic [31:0] eng_rx_data,
   output logic eng_rx_push,
   output logic eng_tx_pop,
   output logic eng_unit_done,
   output logic eng_three_wire_start,
   output logic eng_xfer_done
);
   logic [4:0] stb = 5'h00;
   assign {eng_rx_push, eng_tx_pop, eng_unit_done, eng_three_wire_start, eng_xfer_done} = stb;
   initial begin
      sclk_pin = 1'b0;
      eng_rx_data = 32'h0000_0000;
   end
   // Data lines carry the inverse after a strobe, so a stale word can never pass as new.
   task automatic strobe(input logic [4:0] s, input logic [31:0] d);
      @(posedge pclk);
      stb <= s;
      eng_rx_data <= d;
      @(posedge pclk);
      stb <= 5'h00;
      eng_rx_data <= ~d;
   endtask
   // The serial clock runs only inside a frame, off the pclk phase, and rests low between.
   task automatic sclk_burst(input int n);
      #1.3;
      repeat (n) begin
         #80 sclk_pin = 1'b1;
         #80 sclk_pin = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/* Self-checking bench of the SPI FIFO control block over APB.
   Assumes the package, design, engine model and checker compile first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic [7:0] CTL = sfcs_pkg::ADDR_FIFO_CTL, STS = sfcs_pkg::ADDR_FIFO_STS;
   localparam logic [7:0] RXD = sfcs_pkg::ADDR_RX_DATA, TXD = sfcs_pkg::ADDR_TX_DATA;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic pclk, presetn, psel, penable, pwrite, master_mode, pready, pslverr, irq, err;
   logic eng_tx_valid, sclk_pin, rx_push, tx_pop, u_done, tw_start, x_done;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, rx_data, tx_data;
   sfcs_pkg::sfcs_mirror_t mirror_out;
   int miscompares = 0;
   int tests_run = 0;
   sfcs_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .master_mode(master_mode), .sclk_pin(sclk_pin), .eng_tx_data(tx_data),
      .eng_tx_valid(eng_tx_valid), .eng_tx_pop(tx_pop), .eng_rx_data(rx_data),
      .eng_rx_push(rx_push), .eng_unit_done(u_done), .eng_three_wire_start(tw_start),
      .eng_xfer_done(x_done), .mirror_unit_done_clr(1'b0), .mirror_target_start_clr(1'b0),
      .mirror_out(mirror_out));
   sfcs_engine_model eng (.pclk(pclk), .sclk_pin(sclk_pin), .eng_rx_data(rx_data),
      .eng_rx_push(rx_push), .eng_tx_pop(tx_pop), .eng_unit_done(u_done),
      .eng_three_wire_start(tw_start), .eng_xfer_done(x_done));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      tests_run++;
      if ((got & m) !== (exp & m)) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The answer is read where it is settled, then the completing edge is let pass.
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         close_out();
      end else begin
         rd = prdata;
         err = pslverr;
         @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rd, e, m);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge pclk);
      cmp({31'h0, irq}, {31'h0, e}, 32'h0000_0001);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, master_mode, presetn} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk(STS, 32'h0500_0010, ALL);
      chk(CTL, 32'h2200_0000, ALL);
      apb(1'b0, 8'h00, 32'h0000_0000);
      cmp({31'h0, err}, 32'h0000_0001, 32'h0000_0001);
      for (int i = 0; i < 3; i++) apb(1'b1, TXD, 32'h0000_00C0 + 32'(i));
      chk(STS, 32'h3100_0000, 32'hFF00_0010);
      apb(1'b1, CTL, 32'h2200_0008);
      chk_irq(1'b0);
      eng.strobe(5'b01000, 32'h0000_0000);
      chk_irq(1'b1);
      cmp(tx_data, 32'h0000_00C1, ALL);
      apb(1'b1, CTL, 32'h2200_000A);
      chk(CTL, 32'h2200_0008, ALL);
      chk(STS, 32'h0500_0010, 32'hFF00_0010);
      apb(1'b1, CTL, 32'h2200_0004);
      chk_irq(1'b0);
      for (int i = 0; i < 5; i++) begin
         eng.strobe(5'b10000, 32'h0000_00A0 + 32'(i));
         if (i == 2) chk_irq(1'b1);
      end
      chk(STS, 32'h0600_4015, 32'hFF00_F015);
      apb(1'b1, CTL, 32'h2200_0040);
      chk_irq(1'b1);
      apb(1'b1, STS, 32'h0000_0004);
      chk_irq(1'b0);
      for (int i = 0; i < 4; i++) chk(RXD, 32'h0000_00A0 + 32'(i), ALL);
      eng.strobe(5'b10000, 32'h0000_0055);
      apb(1'b1, CTL, 32'h2220_0001);
      chk(STS, 32'h0500_0010, 32'hFF10_F000);
      // Slave mode: the idle limit counts pclk periods.
      eng.strobe(5'b10000, 32'h0000_0066);
      repeat (560) @(posedge pclk);
      chk(STS, 32'h0000_0000, 32'h0010_0000);
      repeat (30) @(posedge pclk);
      chk(STS, 32'h0010_0000, 32'h0010_0000);
      chk_irq(1'b1);
      apb(1'b1, STS, 32'h0010_0000);
      chk(STS, 32'h0000_0000, 32'h0010_0000);
      master_mode <= 1'b1;
      apb(1'b1, CTL, 32'h2200_0001);
      eng.strobe(5'b10000, 32'h0000_0077);
      eng.sclk_burst(64);
      repeat (8) @(posedge pclk);
      chk(STS, 32'h0000_0000, 32'h0010_0000);
      eng.sclk_burst(1);
      repeat (8) @(posedge pclk);
      chk(STS, 32'h0010_0000, 32'h0010_0000);
      chk(RXD, 32'h0000_0077, ALL);
      chk(STS, 32'h0000_0000, 32'h0010_0000);
      apb(1'b1, CTL, 32'h2200_0000);
      eng.strobe(5'b00100, 32'h0000_0000);
      chk(STS, 32'h0001_0000, 32'h0001_0000);
      chk(sfcs_pkg::ADDR_EVT_STS, 32'h0001_0000, 32'h0001_0000);
      apb(1'b1, sfcs_pkg::ADDR_EVT_EN, 32'h0001_0000);
      chk_irq(1'b1);
      apb(1'b1, sfcs_pkg::ADDR_EVT_CLR, 32'h0001_0000);
      chk_irq(1'b0);
      apb(1'b1, STS, 32'h0001_0000);
      chk(STS, 32'h0000_0000, 32'h0001_0000);
      eng.strobe(5'b00010, 32'h0000_0000);
      chk(STS, 32'h0000_0800, 32'h0000_0800);
      eng.strobe(5'b00001, 32'h0000_0000);
      chk(STS, 32'h0000_0000, 32'h0000_0800);
      close_out();
   end
endmodule
`default_nettype wire
